// ---- src/lsmu_core.sv ----
`timescale 1ns/1ns
// Behaviour
// - load fills each listed register from memory
// - store writes each listed register to memory
// - two modes, increment-after is default
// - ascending addresses step four, write back last
// - ascending mode walks registers low to high
// - descending addresses step four, write back last
// - descending mode walks registers high to low
// - base updated only when write-back requested
// - stack alias suffixes fold onto base forms
// - loading program counter branches, bit0 must be set
// - no condition flags are ever modified
// - cacheable preload fetches line into cache
// - uncacheable or cache off: preload does nothing
// - register preload shifts index by zero-three
// - immediate preload adds signed offset, default zero
module lsmu_core #(
  parameter logic [31:0] LINE_SIZE = lsmu_pkg::LINE_BYTES // cache line bytes, power of two
) (
  input wire logic core_clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic cmd_valid, // instruction offered
  output logic cmd_ready, // unit idle, takes instruction
  input wire lsmu_pkg::lsmu_cmd_s cmd, // decoded instruction
  output logic [3:0] rf_rd_idx, // register file read index
  input wire logic [31:0] rf_rd_data, // register file read data, same cycle
  output lsmu_pkg::lsmu_rf_wr_s rf_wr, // register file write, registered
  output logic mem_req_valid, // word request offered
  input wire logic mem_req_ready, // memory takes request
  output lsmu_pkg::lsmu_mem_req_s mem_req, // request payload, registered
  input wire logic mem_rsp_valid, // access finished
  input wire logic [31:0] mem_rsp_data, // load data
  input wire logic dc_enable, // data cache enabled
  input wire logic pld_cacheable, // preload address is cacheable
  output logic pld_req_valid, // line fill request
  input wire logic pld_req_ready, // line fill accepted
  output logic [31:0] pld_line_addr, // line address, registered
  output logic branch_valid, // branch to loaded counter, pulse
  output logic [31:0] branch_target, // halfword aligned target
  output logic branch_bit0_err, // loaded counter had bit0 clear
  output logic done // instruction retires, pulse
);

  // line offset mask; the line size must be a power of two
  localparam logic [31:0] LINE_MASK = ~(LINE_SIZE - lsmu_pkg::WORD_STEP / lsmu_pkg::WORD_STEP);

  // fold the written suffix onto the two hardware modes
  function automatic lsmu_pkg::lsmu_mode_e fold_mode(input lsmu_pkg::lsmu_op_e op,
                                                    input lsmu_pkg::lsmu_sfx_e sfx);
    lsmu_pkg::lsmu_mode_e m;
    m = lsmu_pkg::LSMU_MODE_INC_AFTER; // no suffix means increment-after
    case (sfx)
      lsmu_pkg::LSMU_SFX_DEC_BEFORE: m = lsmu_pkg::LSMU_MODE_DEC_BEFORE;
      lsmu_pkg::LSMU_SFX_EMPTY_ASC: begin
        // empty-ascending pops descend, pushes ascend
        if (op == lsmu_pkg::LSMU_OP_LOAD) begin
          m = lsmu_pkg::LSMU_MODE_DEC_BEFORE;
        end
      end
      lsmu_pkg::LSMU_SFX_FULL_DESC: begin
        // full-descending pushes descend, pops ascend
        if (op == lsmu_pkg::LSMU_OP_STORE) begin
          m = lsmu_pkg::LSMU_MODE_DEC_BEFORE;
        end
      end
      default: m = lsmu_pkg::LSMU_MODE_INC_AFTER;
    endcase
    return m;
  endfunction

  // sequencer and captured instruction
  lsmu_pkg::lsmu_state_e state, next_state;
  logic is_load, next_is_load; // load rather than store
  lsmu_pkg::lsmu_mode_e mode, next_mode; // folded addressing mode
  logic wb, next_wb; // write-back requested
  logic [3:0] base_idx, next_base_idx; // base register number
  logic [15:0] remaining, next_remaining; // registers still to move
  logic [31:0] cur_addr, next_cur_addr; // address of next access
  logic [31:0] last_addr, next_last_addr; // address of last access
  logic [3:0] cur_idx, next_cur_idx; // register of the access in flight
  // outputs held in flops
  lsmu_pkg::lsmu_mem_req_s next_mem_req;
  lsmu_pkg::lsmu_rf_wr_s next_rf_wr;
  logic [31:0] next_pld_line_addr;
  logic branch_pend, next_branch_pend; // counter was in a load list
  logic [31:0] next_branch_target;
  logic next_branch_bit0_err;
  // next register chosen from the list
  logic [3:0] pick_idx;
  logic pick_found;
  logic [15:0] rem_after; // list with current register removed
  logic [31:0] pld_addr; // computed preload address

  // descending mode takes the highest register first
  lsmu_pick #(
    .WIDTH(lsmu_pkg::REG_COUNT),
    .IDX_W(lsmu_pkg::REG_IDX_W)
  ) u_pick (
    .mask(remaining),
    .highest(mode == lsmu_pkg::LSMU_MODE_DEC_BEFORE),
    .idx(pick_idx),
    .found(pick_found)
  );

  // preload address: register form shifts the index, immediate form
  // sign-extends the offset; an omitted field arrives as zero
  always_comb begin
    if (cmd.pld_form == lsmu_pkg::LSMU_PLD_REG) begin
      pld_addr = cmd.base_value + (cmd.index_value << cmd.shift);
    end else begin
      pld_addr = cmd.base_value + 32'(cmd.pld_imm);
    end
  end

  // handshake outputs decode straight from the state; the line fill request also needs dc_enable and pld_cacheable
  always_comb begin
    cmd_ready = (state == lsmu_pkg::LSMU_ST_IDLE);
    mem_req_valid = (state == lsmu_pkg::LSMU_ST_REQ);
    pld_req_valid = (state == lsmu_pkg::LSMU_ST_PLD) && dc_enable && pld_cacheable;
    done = (state == lsmu_pkg::LSMU_ST_DONE);
    branch_valid = done && branch_pend;
    rf_rd_idx = pick_idx;
    rem_after = remaining & ~(16'h0001 << cur_idx);
  end

  // next-state and datapath; condition flags have no port at all
  always_comb begin
    next_state = state;
    next_is_load = is_load;
    next_mode = mode;
    next_wb = wb;
    next_base_idx = base_idx;
    next_remaining = remaining;
    next_cur_addr = cur_addr;
    next_last_addr = last_addr;
    next_cur_idx = cur_idx;
    next_mem_req = mem_req;
    next_rf_wr = '0; // write port is a one-cycle pulse
    next_pld_line_addr = pld_line_addr;
    next_branch_pend = branch_pend;
    next_branch_target = branch_target;
    next_branch_bit0_err = branch_bit0_err;
    case (state)
      lsmu_pkg::LSMU_ST_IDLE: begin
        if (cmd_valid) begin
          next_branch_pend = 1'b0;
          next_branch_bit0_err = 1'b0;
          if (cmd.op == lsmu_pkg::LSMU_OP_PRELOAD) begin
            next_pld_line_addr = pld_addr & LINE_MASK;
            next_state = lsmu_pkg::LSMU_ST_PLD;
          end else begin
            next_is_load = (cmd.op == lsmu_pkg::LSMU_OP_LOAD);
            next_mode = fold_mode(cmd.op, cmd.sfx);
            next_wb = cmd.writeback;
            next_base_idx = cmd.base_idx;
            next_remaining = cmd.reg_list;
            next_cur_addr = cmd.base_value; // first access at the base
            next_last_addr = cmd.base_value;
            next_state = lsmu_pkg::LSMU_ST_READ;
          end
        end
      end
      lsmu_pkg::LSMU_ST_READ: begin
        // an empty list moves nothing and goes straight to write-back
        if (pick_found) begin
          next_cur_idx = pick_idx;
          next_mem_req.write = !is_load;
          next_mem_req.addr = cur_addr;
          next_mem_req.wdata = is_load ? lsmu_pkg::ADDR_ZERO : rf_rd_data;
          next_state = lsmu_pkg::LSMU_ST_REQ;
        end else begin
          next_state = lsmu_pkg::LSMU_ST_WB;
        end
      end
      lsmu_pkg::LSMU_ST_REQ: begin
        if (mem_req_ready) begin
          next_state = lsmu_pkg::LSMU_ST_RSP;
        end
      end
      lsmu_pkg::LSMU_ST_RSP: begin
        // one access at a time keeps the word order strict
        if (mem_rsp_valid) begin
          if (is_load) begin
            next_rf_wr.en = 1'b1;
            next_rf_wr.idx = cur_idx;
            next_rf_wr.data = mem_rsp_data;
            if (cur_idx == lsmu_pkg::PC_IDX) begin
              // target is halfword aligned; bit0 is the state bit
              next_branch_pend = 1'b1;
              next_branch_target = {mem_rsp_data[31:1], 1'b0};
              next_branch_bit0_err = !mem_rsp_data[0];
            end
          end
          next_last_addr = cur_addr;
          next_remaining = rem_after;
          if (mode == lsmu_pkg::LSMU_MODE_INC_AFTER) begin
            next_cur_addr = cur_addr + lsmu_pkg::WORD_STEP;
          end else begin
            next_cur_addr = cur_addr - lsmu_pkg::WORD_STEP;
          end
          next_state = (rem_after == lsmu_pkg::LIST_EMPTY) ? lsmu_pkg::LSMU_ST_WB
                                                           : lsmu_pkg::LSMU_ST_READ;
        end
      end
      lsmu_pkg::LSMU_ST_WB: begin
        // final transfer address goes back only with write-back
        if (wb) begin
          next_rf_wr.en = 1'b1;
          next_rf_wr.idx = base_idx;
          next_rf_wr.data = last_addr;
        end
        next_state = lsmu_pkg::LSMU_ST_DONE;
      end
      lsmu_pkg::LSMU_ST_PLD: begin
        // uncached or cache off: retire with no request at all
        if (!(dc_enable && pld_cacheable)) begin
          next_state = lsmu_pkg::LSMU_ST_DONE;
        end else if (pld_req_ready) begin
          next_state = lsmu_pkg::LSMU_ST_DONE;
        end
      end
      lsmu_pkg::LSMU_ST_DONE: begin
        next_state = lsmu_pkg::LSMU_ST_IDLE;
      end
      default: next_state = lsmu_pkg::LSMU_ST_IDLE;
    endcase
  end

  // register all state and registered outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= lsmu_pkg::LSMU_ST_IDLE;
      is_load <= 1'b0;
      mode <= lsmu_pkg::LSMU_MODE_INC_AFTER;
      wb <= 1'b0;
      base_idx <= '0;
      remaining <= lsmu_pkg::LIST_EMPTY;
      cur_addr <= lsmu_pkg::ADDR_ZERO;
      last_addr <= lsmu_pkg::ADDR_ZERO;
      cur_idx <= '0;
      mem_req <= '0;
      rf_wr <= '0;
      pld_line_addr <= lsmu_pkg::ADDR_ZERO;
      branch_pend <= 1'b0;
      branch_target <= lsmu_pkg::ADDR_ZERO;
      branch_bit0_err <= 1'b0;
    end else begin
      state <= next_state;
      is_load <= next_is_load;
      mode <= next_mode;
      wb <= next_wb;
      base_idx <= next_base_idx;
      remaining <= next_remaining;
      cur_addr <= next_cur_addr;
      last_addr <= next_last_addr;
      cur_idx <= next_cur_idx;
      mem_req <= next_mem_req;
      rf_wr <= next_rf_wr;
      pld_line_addr <= next_pld_line_addr;
      branch_pend <= next_branch_pend;
      branch_target <= next_branch_target;
      branch_bit0_err <= next_branch_bit0_err;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ascending walk steps up one word per access
  asc_step_a: assert property (
    (state == lsmu_pkg::LSMU_ST_RSP && mem_rsp_valid && mode == lsmu_pkg::LSMU_MODE_INC_AFTER)
    |=> cur_addr == $past(cur_addr) + lsmu_pkg::WORD_STEP)
    else $error("ascending address did not step by one word");

  // descending walk steps down one word per access
  desc_step_a: assert property (
    (state == lsmu_pkg::LSMU_ST_RSP && mem_rsp_valid && mode == lsmu_pkg::LSMU_MODE_DEC_BEFORE)
    |=> cur_addr == $past(cur_addr) - lsmu_pkg::WORD_STEP)
    else $error("descending address did not step by one word");

  // ascending mode leaves nothing lower than the register in flight
  asc_order_a: assert property (
    (mem_req_valid && mode == lsmu_pkg::LSMU_MODE_INC_AFTER)
    |-> ((remaining & ((16'h0001 << cur_idx) - 16'h0001)) == lsmu_pkg::LIST_EMPTY))
    else $error("ascending order broken");

  // descending mode leaves nothing higher than the register in flight
  desc_order_a: assert property (
    (mem_req_valid && mode == lsmu_pkg::LSMU_MODE_DEC_BEFORE)
    |-> ((remaining >> cur_idx) == 16'h0001))
    else $error("descending order broken");

  // write-back carries the last address, or nothing is written
  wb_value_a: assert property (
    (state == lsmu_pkg::LSMU_ST_WB)
    |=> (rf_wr.en == $past(wb)) && (!rf_wr.en || (rf_wr.data == $past(last_addr)
        && rf_wr.idx == $past(base_idx))))
    else $error("base write-back wrong");

  // each load response lands in the register file next cycle
  load_write_a: assert property (
    (state == lsmu_pkg::LSMU_ST_RSP && mem_rsp_valid && is_load)
    |=> rf_wr.en && rf_wr.data == $past(mem_rsp_data) && rf_wr.idx == $past(cur_idx))
    else $error("loaded word not written");

  // a branch always goes to a halfword-aligned target at retire
  branch_align_a: assert property (
    branch_valid |-> done && !branch_target[0])
    else $error("branch target misaligned or early");

  // preload with no cache effect retires next cycle without a request
  pld_none_a: assert property (
    (state == lsmu_pkg::LSMU_ST_PLD && !(dc_enable && pld_cacheable))
    |-> !pld_req_valid ##1 done)
    else $error("uncached preload raised a request");

  // retire only once the whole list has moved
  retire_list_a: assert property (
    done |-> remaining == lsmu_pkg::LIST_EMPTY)
    else $error("retired with registers left");

  // register-form preload line address follows the shifted index
  pld_shift_a: assert property (
    (cmd_ready && cmd_valid && cmd.op == lsmu_pkg::LSMU_OP_PRELOAD
     && cmd.pld_form == lsmu_pkg::LSMU_PLD_REG)
    |=> pld_line_addr == (($past(cmd.base_value) + ($past(cmd.index_value) << $past(cmd.shift)))
        & LINE_MASK))
    else $error("preload register address wrong");

endmodule

// ---- src/lsmu_pick.sv ----
`timescale 1ns/1ns
// finds the lowest or highest set bit of a register list
module lsmu_pick #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned IDX_W = 4
) (
  input wire logic [WIDTH-1:0] mask, // remaining registers
  input wire logic highest, // 1: pick highest, 0: pick lowest
  output logic [IDX_W-1:0] idx, // chosen register number
  output logic found // at least one bit set
);

  // scan in ascending order; last hit wins for highest, first for lowest
  always_comb begin
    idx = '0;
    found = 1'b0;
    for (int i = 0; i < WIDTH; i++) begin
      if (mask[i] && (highest || !found)) begin
        idx = IDX_W'(i);
        found = 1'b1;
      end
    end
  end

endmodule

// ---- src/lsmu_pkg.sv ----
package lsmu_pkg;

  // register file geometry
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned REG_IDX_W = 4;
  localparam logic [3:0] PC_IDX = 4'hF; // program_counter index
  // one word transfer moves the address by this many bytes
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // preload immediate width, signed
  localparam int unsigned IMM_W = 13;
  // default cache line size in bytes
  localparam logic [31:0] LINE_BYTES = 32'h0000_0020;
  // unchanged-value constants
  localparam logic [15:0] LIST_EMPTY = 16'h0000;
  localparam logic [31:0] ADDR_ZERO = 32'h0000_0000;

  // operation class
  typedef enum logic [1:0] {
    LSMU_OP_LOAD,
    LSMU_OP_STORE,
    LSMU_OP_PRELOAD
  } lsmu_op_e;

  // suffix as written by software; stack aliases fold onto two modes
  typedef enum logic [2:0] {
    LSMU_SFX_NONE,
    LSMU_SFX_INC_AFTER,
    LSMU_SFX_DEC_BEFORE,
    LSMU_SFX_FULL_DESC,
    LSMU_SFX_EMPTY_ASC
  } lsmu_sfx_e;

  typedef enum logic {
    LSMU_MODE_INC_AFTER,
    LSMU_MODE_DEC_BEFORE
  } lsmu_mode_e;

  typedef enum logic {
    LSMU_PLD_IMM,
    LSMU_PLD_REG
  } lsmu_pld_e;

  // sequencer states
  typedef enum logic [2:0] {
    LSMU_ST_IDLE,
    LSMU_ST_READ,
    LSMU_ST_REQ,
    LSMU_ST_RSP,
    LSMU_ST_WB,
    LSMU_ST_PLD,
    LSMU_ST_DONE
  } lsmu_state_e;

  // decoded instruction handed over by the issue stage
  typedef struct packed {
    lsmu_op_e op;
    lsmu_sfx_e sfx;
    logic writeback;
    logic [3:0] base_idx;
    logic [15:0] reg_list;
    logic [31:0] base_value;
    lsmu_pld_e pld_form;
    logic signed [12:0] pld_imm;
    logic [31:0] index_value;
    logic [1:0] shift;
  } lsmu_cmd_s;

  // one word request to the memory system
  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lsmu_mem_req_s;

  // register file write port
  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } lsmu_rf_wr_s;

endpackage

// ---- verif/lsmu_mem_model.sv ----
`timescale 1ns/1ns
// memory system and data cache stand-in; random waits when slow is set
module lsmu_mem_model (
  input wire logic core_clk, // core clock
  input wire logic slow, // insert wait states
  input wire logic mem_req_valid, // word request offered
  output logic mem_req_ready, // request taken
  input wire lsmu_pkg::lsmu_mem_req_s mem_req, // request payload
  output logic mem_rsp_valid, // access finished, pulse
  output logic [31:0] mem_rsp_data, // load data
  input wire logic pld_req_valid, // line fill request
  output logic pld_req_ready // line fill taken
);
  logic [31:0] mem [0:255]; // word store, filled by the bench
  lsmu_pkg::lsmu_mem_req_s log_q [$]; // accepted requests in order
  lsmu_pkg::lsmu_mem_req_s req; // request being served
  int pld_count; // accepted line fills
  // random hold-off, zero when fast
  task automatic hold_off();
    repeat (slow ? $urandom % 3 : 0) @(negedge core_clk);
  endtask
  // one access at a time; idle data toggles so stale data never looks valid
  initial begin
    mem_req_ready = 1'b0;
    mem_rsp_valid = 1'b0;
    pld_req_ready = 1'b0;
    mem_rsp_data = 32'h0;
    pld_count = 0;
    forever begin
      @(negedge core_clk);
      mem_rsp_valid = 1'b0;
      mem_req_ready = 1'b0;
      pld_req_ready = 1'b0;
      mem_rsp_data = ~mem_rsp_data;
      if (mem_req_valid) begin
        hold_off();
        mem_req_ready = 1'b1;
        @(posedge core_clk);
        req = mem_req;
        log_q.push_back(req);
        @(negedge core_clk);
        mem_req_ready = 1'b0;
        hold_off();
        mem_rsp_data = mem[req.addr[9:2]];
        if (req.write) mem[req.addr[9:2]] = req.wdata;
        mem_rsp_valid = 1'b1;
      end else if (pld_req_valid) begin
        hold_off();
        pld_req_ready = 1'b1;
        @(posedge core_clk);
        pld_count++; // line fetched into the cache
      end
    end
  end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
// self-checking bench for the block transfer unit
module testbench;
  localparam logic [31:0] LSZ = 32'h0000_0020; // line size handed down
  localparam lsmu_pkg::lsmu_op_e LD = lsmu_pkg::LSMU_OP_LOAD; // load op
  localparam lsmu_pkg::lsmu_op_e ST = lsmu_pkg::LSMU_OP_STORE; // store op
  logic core_clk = 1'b0; // core clock
  logic rstn = 1'b0; // reset, active low
  logic cmd_valid = 1'b0; // instruction offered
  lsmu_pkg::lsmu_cmd_s cmd = '0; // decoded instruction
  logic dc_enable = 1'b0; // cache on
  logic pld_cacheable = 1'b0; // preload address cacheable
  logic slow = 1'b0; // wait states in the memory model
  logic cmd_ready, mem_req_valid, mem_req_ready, mem_rsp_valid; // handshakes
  logic pld_req_valid, pld_req_ready, branch_valid, branch_bit0_err, done; // status
  logic [3:0] rf_rd_idx; // register read index
  logic [31:0] rf_rd_data, mem_rsp_data, pld_line_addr, branch_target; // data
  lsmu_pkg::lsmu_rf_wr_s rf_wr; // register write port
  lsmu_pkg::lsmu_mem_req_s mem_req; // memory request
  logic [31:0] rf [0:15]; // register file kept by the bench
  int err_count = 0; // mismatches
  int checks_done = 0; // comparisons
  int cycles = 0; // hang guard
  logic br_seen, br_err; // branch outputs at retire
  logic [31:0] br_tgt; // branch target at retire

  always #4 core_clk = ~core_clk;
  assign rf_rd_data = rf[rf_rd_idx];
  // register file write, same edge as the unit expects
  always @(posedge core_clk) if (rf_wr.en) rf[rf_wr.idx] <= rf_wr.data;

  lsmu_core #(.LINE_SIZE(LSZ)) lsmu_core_inst (.core_clk(core_clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rf_rd_idx(rf_rd_idx),
    .rf_rd_data(rf_rd_data), .rf_wr(rf_wr), .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready), .mem_req(mem_req), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data), .dc_enable(dc_enable), .pld_cacheable(pld_cacheable),
    .pld_req_valid(pld_req_valid), .pld_req_ready(pld_req_ready),
    .pld_line_addr(pld_line_addr), .branch_valid(branch_valid),
    .branch_target(branch_target), .branch_bit0_err(branch_bit0_err), .done(done));
  lsmu_mem_model lsmu_mem_model_inst (.core_clk(core_clk), .slow(slow),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req(mem_req),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
    .pld_req_valid(pld_req_valid), .pld_req_ready(pld_req_ready));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      finish_test();
    end
  end

  // offer one instruction, wait for retire, capture branch outputs
  task automatic issue(input lsmu_pkg::lsmu_cmd_s c);
    int w;
    @(negedge core_clk);
    cmd = c;
    cmd_valid = 1'b1;
    w = 0;
    while (cmd_ready !== 1'b1 && w < 100) begin
      @(negedge core_clk);
      w++;
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 500) begin
      @(negedge core_clk);
      w++;
    end
    chk("retire", 1'b1, done);
    br_seen = branch_valid;
    br_tgt = branch_target;
    br_err = branch_bit0_err;
    @(negedge core_clk); // write-back lands
  endtask

  // address of the k-th access; descending walks start at the base and go down
  function automatic logic [31:0] exp_addr(input logic dec, input logic [31:0] base,
                                           input int k);
    return dec ? base - lsmu_pkg::WORD_STEP * k : base + lsmu_pkg::WORD_STEP * k;
  endfunction

  // block transfer with expectations worked out from the list
  task automatic run_lsm(input lsmu_pkg::lsmu_op_e op, input lsmu_pkg::lsmu_sfx_e sfx,
                         input logic wb, input logic [3:0] bi, input logic [15:0] lst,
                         input logic [31:0] base);
    lsmu_pkg::lsmu_cmd_s c;
    logic [31:0] orf [0:15];
    logic [31:0] om [0:255];
    logic dec;
    logic [31:0] a, pa;
    lsmu_pkg::lsmu_mem_req_s q; // logged request under check
    int k;
    int r;
    dec = sfx == lsmu_pkg::LSMU_SFX_DEC_BEFORE ||
          sfx == (op == LD ? lsmu_pkg::LSMU_SFX_EMPTY_ASC : lsmu_pkg::LSMU_SFX_FULL_DESC);
    rf[bi] = base;
    orf = rf;
    om = lsmu_mem_model_inst.mem;
    lsmu_mem_model_inst.log_q.delete();
    c = '0;
    c.op = op;
    c.sfx = sfx;
    c.writeback = wb;
    c.base_idx = bi;
    c.reg_list = lst;
    c.base_value = base;
    issue(c);
    chk("transfers", $countones(lst), lsmu_mem_model_inst.log_q.size());
    k = 0;
    a = base;
    pa = base;
    for (int i = 0; i < 16; i++) begin
      r = dec ? 15 - i : i;
      if (lst[r] && k < lsmu_mem_model_inst.log_q.size()) begin
        a = exp_addr(dec, base, k);
        q = lsmu_mem_model_inst.log_q[k];
        if (r == 15) pa = a;
        chk("address", a, q.addr);
        chk("write", op == ST, q.write);
        if (op == ST) chk("store data", orf[r], q.wdata);
        else if (r != 15) chk("load data", om[a[9:2]], rf[r]);
        k++;
      end
    end
    chk("base", wb ? a : base, rf[bi]);
    chk("branch", op == LD && lst[15], br_seen);
    if (op == LD && lst[15]) begin
      chk("target", {om[pa[9:2]][31:1], 1'b0}, br_tgt);
      chk("bit0 flag", !om[pa[9:2]][0], br_err);
    end
  endtask

  // legal random instruction: no SP in list, base kept out of list
  task automatic rnd_lsm(input lsmu_pkg::lsmu_op_e op, input lsmu_pkg::lsmu_sfx_e sfx);
    logic [3:0] bi;
    logic [15:0] lst;
    bi = 4'($urandom % 15); // base is never the counter
    lst = 16'($urandom);
    lst[13] = 1'b0;
    lst[bi] = 1'b0;
    if (op == ST) lst[15] = 1'b0;
    if (lst[15]) lst[14] = 1'b0;
    if (lst == 16'h0000) lst[bi == 4'h0] = 1'b1;
    run_lsm(op, sfx, 1'($urandom), bi, lst, 32'h200 + 32'($urandom % 64) * 4);
  endtask

  // preload hint; only a cacheable access with cache on asks for a line
  task automatic run_pld(input lsmu_pkg::lsmu_pld_e f, input logic signed [12:0] imm,
                         input logic [31:0] idx, input logic [1:0] sh, input logic dc,
                         input logic ca);
    lsmu_pkg::lsmu_cmd_s c;
    logic [31:0] a;
    int n0;
    c = '0;
    c.op = lsmu_pkg::LSMU_OP_PRELOAD;
    c.pld_form = f;
    c.pld_imm = imm;
    c.index_value = idx;
    c.shift = sh;
    c.base_value = $urandom;
    a = f == lsmu_pkg::LSMU_PLD_IMM ? c.base_value + {{19{imm[12]}}, imm}
                                    : c.base_value + (idx << sh);
    dc_enable = dc;
    pld_cacheable = ca;
    n0 = lsmu_mem_model_inst.pld_count;
    lsmu_mem_model_inst.log_q.delete();
    issue(c);
    chk("fills", dc & ca, lsmu_mem_model_inst.pld_count - n0);
    chk("preload words", 0, lsmu_mem_model_inst.log_q.size());
    chk("preload branch", 1'b0, br_seen);
    if (dc & ca) chk("line", a & ~(LSZ - 32'h1), pld_line_addr);
  endtask

  initial begin
    void'($urandom(32'hF1B5CADC));
    for (int i = 0; i < 16; i++) rf[i] = $urandom;
    for (int i = 0; i < 256; i++) lsmu_mem_model_inst.mem[i] = $urandom | 32'h1;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    chk("idle ready", 1'b1, cmd_ready);
    // corners: widest lists, single words, counter bit0 clear
    run_lsm(ST, lsmu_pkg::LSMU_SFX_NONE, 1'b1, 4'h1, 16'h5FFD, 32'h200);
    run_lsm(LD, lsmu_pkg::LSMU_SFX_EMPTY_ASC, 1'b1, 4'hD, 16'h9FFF, 32'h2FC);
    lsmu_mem_model_inst.mem[8'h80][0] = 1'b0;
    // no conditional blocks are issued, so a counter load always ends its block
    run_lsm(LD, lsmu_pkg::LSMU_SFX_NONE, 1'b0, 4'h2, 16'h8000, 32'h200);
    run_lsm(ST, lsmu_pkg::LSMU_SFX_FULL_DESC, 1'b0, 4'h0, 16'h0002, 32'h240);
    // every suffix with both directions
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 5; s++) rnd_lsm(o ? ST : LD, lsmu_pkg::lsmu_sfx_e'(s));
    // random traffic, half of it against a slow memory
    repeat (40) begin
      slow = 1'($urandom);
      rnd_lsm(1'($urandom) ? ST : LD, lsmu_pkg::lsmu_sfx_e'($urandom % 5));
    end
    // both forms, all shifts, all cache states
    run_pld(lsmu_pkg::LSMU_PLD_IMM, 13'sh0000, 32'h0, 2'h0, 1'b1, 1'b1);
    run_pld(lsmu_pkg::LSMU_PLD_IMM, 13'sh1000, 32'h0, 2'h0, 1'b1, 1'b1);
    for (int i = 0; i < 16; i++)
      run_pld(lsmu_pkg::lsmu_pld_e'(i[0]), 13'($urandom), $urandom, i[2:1],
              i[3] | i[0], i[3] | i[1]);
    finish_test();
  end
endmodule
